// [include/stcm_pkg.sv]
// Package with the register map, field layout and widths of the tick block.
// ==========================================================================
// Functional notes
// - A mask bit of one leaves that bit out of the time match.
// - Mask low holds mask bits 31..0, R/W, reset 0, capture mode only; the code accepts writes to it in any mode.
// - Mask high register holds mask bit 32 at bit 0; bits 31..1 read 0.
// - With tick enable and capture mode set and count X, a tick comes every X+1 cycles.
// - The tick counter counts only while tick enable and capture mode are both set.
// - Any write to the tick count register clears the tick counter.
// - At the terminal count the flag sets and the counter returns to 0.
// - Tick terminal count is a 32-bit R/W field, reset 0.
// - Match of unmasked bits with match enable and capture mode set sets the match flag.
package stcm_pkg;
  localparam int          STCM_AW          = 4;
  localparam int          STCM_TW          = 33;
  localparam int          STCM_CW          = 32;
  localparam logic [3:0]  STCM_OFS_MSKL    = 4'h0;
  localparam logic [3:0]  STCM_OFS_MSKM    = 4'h4;
  localparam logic [3:0]  STCM_OFS_TICKS   = 4'h8;
  localparam logic [3:0]  STCM_OFS_CTRL    = 4'hC;
  localparam int          STCM_CTRL_TICK_EN  = 0;
  localparam int          STCM_CTRL_MATCH_EN = 1;
  localparam int          STCM_CTRL_CAPT   = 2;
  localparam int          STCM_ST_TICK     = 8;
  localparam int          STCM_ST_MATCH    = 9;
  localparam logic [31:0] STCM_RST_WORD    = 32'h0000_0000;
endpackage : stcm_pkg

// [include/stcm_tick_if.sv]
// Interface between the register top and the tick counter.
// ==========================================================================
`timescale 1ns/1ns
interface stcm_tick_if;
  logic        run;
  logic        clr;
  logic [31:0] terminal;
  logic        tick;
  logic [31:0] count;
  modport ctl (output run, output clr, output terminal,
               input tick, input count);
  modport cnt (input run, input clr, input terminal,
               output tick, output count);
endinterface : stcm_tick_if

// [rtl/stcm_tick_counter.sv]
// Free tick counter that pulses at its terminal count.
// ==========================================================================
`timescale 1ns/1ns
module stcm_tick_counter (
  input  wire logic clk,
  input  wire logic nrst,
  stcm_tick_if.cnt  tk
);
  import stcm_pkg::*;

  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic        tick_r;
  logic        tick_nxt;

  // ==========================================================================
  // Counter
  always_comb begin
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (tk.clr) begin
      cnt_nxt = '0;
    end else if (tk.run) begin
      if (cnt_r == tk.terminal) begin
        cnt_nxt  = '0;
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_r  <= STCM_RST_WORD;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tk.tick  = tick_r;
  assign tk.count = cnt_r;

  a_tick_at_term: assert property (@(posedge clk) disable iff (!nrst)
    (tk.run && !tk.clr && cnt_r == tk.terminal) |=> (tick_r && cnt_r == 0))
    else $error("tick missing at terminal count");
  a_clear_on_write: assert property (@(posedge clk) disable iff (!nrst)
    tk.clr |=> (cnt_r == 0 && !tick_r))
    else $error("counter not cleared by write");
  a_hold_when_off: assert property (@(posedge clk) disable iff (!nrst)
    (!tk.run && !tk.clr) |=> $stable(cnt_r))
    else $error("counter moved while disabled");
endmodule : stcm_tick_counter

// [rtl/stcm_top.sv]
// Compare mask and tick interval registers with match and tick flags.
// ==========================================================================
`timescale 1ns/1ns
module stcm_top (
  input  wire logic                           clk,
  input  wire logic                           nrst,
  input  wire logic [stcm_pkg::STCM_AW-1:0]   addr,
  input  wire logic [31:0]                    wdata,
  input  wire logic                           wr,
  input  wire logic                           rd,
  output logic      [31:0]                    rdata,
  input  wire logic [stcm_pkg::STCM_TW-1:0]   system_time_counter,
  input  wire logic [stcm_pkg::STCM_TW-1:0]   absolute_time_compare,
  output logic                                time_match_flag,
  output logic                                tick_flag
);
  import stcm_pkg::*;

  stcm_tick_if tk ();

  logic [31:0] mskl_r, mskl_nxt;
  logic        mskm_r, mskm_nxt;
  logic [31:0] term_r, term_nxt;
  logic [2:0]  ctrl_r, ctrl_nxt;
  logic        tflag_r, tflag_nxt;
  logic        mflag_r, mflag_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        match_r, match_nxt;
  logic [STCM_TW-1:0] mask;
  logic        hit;
  logic        wr_ctrl;

  // ==========================================================================
  // Compare
  assign mask = {mskm_r, mskl_r};
  // Match on every bit whose mask bit is zero; capture mode only.
  assign hit = ((system_time_counter ^ absolute_time_compare) & ~mask)
               == '0;
  assign match_nxt = hit && ctrl_r[STCM_CTRL_CAPT];
  assign wr_ctrl   = wr && addr == STCM_OFS_CTRL;

  // ==========================================================================
  // Registers
  always_comb begin
    mskl_nxt  = mskl_r;
    mskm_nxt  = mskm_r;
    term_nxt  = term_r;
    ctrl_nxt  = ctrl_r;
    tflag_nxt = tflag_r;
    mflag_nxt = mflag_r;
    rdata_nxt = STCM_RST_WORD;
    if (wr) begin
      case (addr)
        STCM_OFS_MSKL:  mskl_nxt = wdata;
        STCM_OFS_MSKM:  mskm_nxt = wdata[0];
        STCM_OFS_TICKS: term_nxt = wdata;
        STCM_OFS_CTRL: begin
          ctrl_nxt = wdata[2:0];
          if (wdata[STCM_ST_TICK]) tflag_nxt = 1'b0;
          if (wdata[STCM_ST_MATCH]) mflag_nxt = 1'b0;
        end
        default: ;
      endcase
    end
    // Hardware set wins over a software clear in the same cycle.
    if (tk.tick) tflag_nxt = 1'b1;
    if (match_r && ctrl_r[STCM_CTRL_MATCH_EN]) mflag_nxt = 1'b1;
    if (rd) begin
      case (addr)
        STCM_OFS_MSKL:  rdata_nxt = mskl_r;
        STCM_OFS_MSKM:  rdata_nxt = {31'h0000_0000, mskm_r};
        STCM_OFS_TICKS: rdata_nxt = term_r;
        STCM_OFS_CTRL: begin
          rdata_nxt[2:0]           = ctrl_r;
          rdata_nxt[STCM_ST_TICK]  = tflag_r;
          rdata_nxt[STCM_ST_MATCH] = mflag_r;
        end
        default: rdata_nxt = STCM_RST_WORD;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      mskl_r  <= STCM_RST_WORD;
      mskm_r  <= 1'b0;
      term_r  <= STCM_RST_WORD;
      ctrl_r  <= 3'h0;
      tflag_r <= 1'b0;
      mflag_r <= 1'b0;
      rdata_r <= STCM_RST_WORD;
      match_r <= 1'b0;
    end else begin
      mskl_r  <= mskl_nxt;
      mskm_r  <= mskm_nxt;
      term_r  <= term_nxt;
      ctrl_r  <= ctrl_nxt;
      tflag_r <= tflag_nxt;
      mflag_r <= mflag_nxt;
      rdata_r <= rdata_nxt;
      match_r <= match_nxt;
    end
  end

  // ==========================================================================
  // Tick counter
  assign tk.run      = ctrl_r[STCM_CTRL_TICK_EN] && ctrl_r[STCM_CTRL_CAPT];
  assign tk.clr      = wr && addr == STCM_OFS_TICKS;
  assign tk.terminal = term_r;

  stcm_tick_counter stcm_tick_counter_i (
    .clk  (clk),
    .nrst (nrst),
    .tk   (tk)
  );

  assign rdata           = rdata_r;
  assign tick_flag       = tflag_r;
  assign time_match_flag = mflag_r;

  // ==========================================================================
  // Checks
  sequence s_tick_seen;
    tk.tick;
  endsequence
  a_tick_sets_flag: assert property (@(posedge clk) disable iff (!nrst)
    s_tick_seen |=> tflag_r)
    else $error("tick flag not set");
  a_flag_sticks: assert property (@(posedge clk) disable iff (!nrst)
    (tflag_r && !(wr_ctrl && wdata[STCM_ST_TICK])) |=> tflag_r)
    else $error("tick flag dropped by itself");
  a_match_sets: assert property (@(posedge clk) disable iff (!nrst)
    (match_nxt && ctrl_r[STCM_CTRL_MATCH_EN] && !wr_ctrl) ##1
    ctrl_r[STCM_CTRL_MATCH_EN] |=> mflag_r)
    else $error("match flag not set");
  a_mskm_upper_zero: assert property (@(posedge clk) disable iff (!nrst)
    (rd && addr == STCM_OFS_MSKM) |=> rdata_r[31:1] == '0)
    else $error("upper mask bits not zero");
  a_mskl_readback: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == STCM_OFS_MSKL) ##1 (rd && addr == STCM_OFS_MSKL)
    |=> rdata_r == $past(wdata, 2))
    else $error("mask low readback wrong");
  a_term_readback: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == STCM_OFS_TICKS) ##1 (rd && addr == STCM_OFS_TICKS)
    |=> rdata_r == $past(wdata, 2))
    else $error("terminal count readback wrong");
  a_count_free: assert property (@(posedge clk) disable iff (!nrst)
    (tk.run && !tk.clr && tk.count != term_r) |=>
    tk.count == $past(tk.count) + 32'h0000_0001)
    else $error("tick counter skipped a cycle");
endmodule : stcm_top

// [dv/stcm_bench.sv]
// Self-checking bench for the compare mask and tick interval block.
// ==========================================================================
`timescale 1ns/1ns
module stcm_bench;
  import stcm_pkg::*;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic [32:0] time_cnt_r = 33'h0;
  logic [32:0] cmp_val_r = 33'h055;
  logic        time_match_flag;
  logic        tick_flag;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          n;
  always #5 clk = ~clk;
  stcm_top stcm_top_i (
    .clk                   (clk),
    .nrst                  (nrst),
    .addr                  (addr),
    .wdata                 (wdata),
    .wr                    (wr),
    .rd                    (rd),
    .rdata                 (rdata),
    .system_time_counter   (time_cnt_r),
    .absolute_time_compare (cmp_val_r),
    .time_match_flag       (time_match_flag),
    .tick_flag             (tick_flag)
  );
  // ========================================================================
  // Shared tasks
  task automatic summarize;
    if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    chk({1'b0, rdata}, {1'b0, exp});
  endtask : rd_chk
  // Write followed at once by a read of the same register.
  task automatic wr_rd_chk(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    rd    <= 1'b1;
    @(posedge clk);
    rd    <= 1'b0;
    @(negedge clk);
    chk({1'b0, rdata}, {1'b0, d});
  endtask : wr_rd_chk
  // Counts falling edges until the chosen flag is seen high.
  task automatic wait_flag(input bit sel, input int lim, output int cnt);
    cnt = 0;
    do begin
      @(negedge clk);
      cnt++;
    end while ((sel ? time_match_flag : tick_flag) !== 1'b1 && cnt < lim);
    if ((sel ? time_match_flag : tick_flag) !== 1'b1) begin
      $display("wrong value at %0t: got %h expected %h", $time, 1'b0, 1'b1);
      n_mismatch++;
      summarize();
    end
  endtask : wait_flag
  // ========================================================================
  // Scenarios
  task automatic regs_scn;
    rd_chk(STCM_OFS_MSKL, 32'h0);
    rd_chk(STCM_OFS_MSKM, 32'h0);
    rd_chk(STCM_OFS_TICKS, 32'h0);
    wr_reg(STCM_OFS_MSKL, 32'hA5C3_F00F);
    wr_reg(STCM_OFS_MSKM, 32'hFFFF_FFFF);
    wr_reg(STCM_OFS_TICKS, 32'hDEAD_BEEF);
    rd_chk(STCM_OFS_MSKL, 32'hA5C3_F00F);
    rd_chk(STCM_OFS_MSKM, 32'h0000_0001);
    rd_chk(STCM_OFS_TICKS, 32'hDEAD_BEEF);
    wr_rd_chk(STCM_OFS_MSKL, 32'h5A3C_0FF0);
    wr_rd_chk(STCM_OFS_TICKS, 32'h1234_5678);
    rd_chk(4'h2, 32'h0);
  endtask : regs_scn
  task automatic tick_scn;
    wr_reg(STCM_OFS_CTRL, 32'h004);
    wr_reg(STCM_OFS_TICKS, 32'h7);
    wr_reg(STCM_OFS_CTRL, 32'h105);
    wait_flag(1'b0, 40, n);
    chk(n, 10);
    wr_reg(STCM_OFS_CTRL, 32'h105);
    wait_flag(1'b0, 40, n);
    chk(n, 7);
    wr_reg(STCM_OFS_CTRL, 32'h104);
    wr_reg(STCM_OFS_TICKS, 32'h7);
    wr_reg(STCM_OFS_CTRL, 32'h105);
    wait_flag(1'b0, 40, n);
    chk(n, 10);
    wr_reg(STCM_OFS_CTRL, 32'h004);
    repeat (20) @(negedge clk);
    chk(tick_flag, 1'b1);
    rd_chk(STCM_OFS_CTRL, 32'h104);
    wr_reg(STCM_OFS_CTRL, 32'h104);
    repeat (20) @(negedge clk);
    chk(tick_flag, 1'b0);
  endtask : tick_scn
  task automatic match_scn;
    wr_reg(STCM_OFS_MSKL, 32'h0000_0001);
    wr_reg(STCM_OFS_MSKM, 32'h0000_0001);
    wr_reg(STCM_OFS_CTRL, 32'h006);
    repeat (5) @(negedge clk);
    chk(time_match_flag, 1'b0);
    @(posedge clk);
    cmp_val_r <= 33'h1_0000_0001;
    wait_flag(1'b1, 3, n);
    chk(time_match_flag, 1'b1);
    @(posedge clk);
    time_cnt_r <= 33'h0_0000_0002;
    wr_reg(STCM_OFS_CTRL, 32'h206);
    repeat (10) @(negedge clk);
    chk(time_match_flag, 1'b0);
  endtask : match_scn
  // ========================================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    regs_scn();
    tick_scn();
    match_scn();
    summarize();
  end
endmodule : stcm_bench
